/* File: pkg/cies_consts.svh */
// constants for the instruction execution subset
// What this block does
// - decrement_skip_if_zero (00 1011) subtracts one from the file register and leaves flags alone.
// - a zero result of decrement_skip_if_zero flushes the prefetched word and runs a no-op instead.
// - destination bit 0 sends the result to the accumulator, 1 back to the file register.
// - the branch loads pc bits 10..0 from the immediate and bits 12..11 from upper_pc_latch bits 4..3.
// - the branch takes two cycles and changes no flag.
// - increment_register (00 1010) adds one, routes by destination and updates zero_flag in one cycle.
// - move_register (00 1000) copies the register to the destination and sets zero_flag from the value.
// - store_accumulator (00 0000 1fff ffff) writes the accumulator to the register, flags unchanged.
// - the load-configuration word 00 0000 0110 0010 copies the accumulator to timer_pin_config.
// - xor_literal (11 1010) xors the accumulator with the literal into the accumulator, updating zero_flag.
// - xor_register (00 0110) xors accumulator and register, routes by destination, updates zero_flag.
// - the program counter is 13 bits; a pcl write loads bits 12..8 from upper_pc_latch, a branch only bits 12..11.
`ifndef CIES_CONSTS_SVH
`define CIES_CONSTS_SVH
`define CIES_OPT_ADDR 8'h81
`define CIES_OPT_RESET 8'hff
`define CIES_PCL_ADDR 8'h02
`define CIES_UPL_ADDR 8'h0a
`define CIES_STATUS_ADDR 8'h03
`define CIES_W_ADDR 8'h90
`define CIES_PC_ADDR 8'h91
`define CIES_Z_BIT 2
`define CIES_OP_DEC 4'hb
`define CIES_OP_INC 4'ha
`define CIES_OP_MOV 4'h8
`define CIES_OP_XOR 4'h6
`define CIES_OP_XORL 4'ha
`define CIES_W_OPTLOAD 14'h0062
`endif

/* File: pkg/cies_pkg.sv */
// types for the instruction execution subset
package cies_pkg;
  typedef enum logic [1:0] {
    CIES_RUN = 2'b00,
    CIES_FLUSH = 2'b01
  } cies_state_type;
endpackage

/* File: core/cies_core.sv */
// instruction decode and execution for the subset
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "cies_consts.svh"
module cies_core import cies_pkg::*; #(
  parameter int PC_W = 13,
  parameter int ADDR_W = 7
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  output logic [PC_W-1:0] pc,
  output logic instr_taken,
  output logic [ADDR_W-1:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic [7:0] file_wdata,
  output logic file_we,
  output logic [7:0] working_accumulator,
  output logic zero_flag,
  output logic [7:0] timer_pin_config,
  output logic illegal_op,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  cies_state_type state_r;
  logic [4:0] upper_pc_latch_r;
  logic [7:0] res;
  logic wr_w, wr_f, set_z, is_branch, is_skip, known;
  logic [ADDR_W-1:0] fa;
  logic dsel;

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  // file access is combinational from the word; register file answers same cycle
  assign fa = instr[ADDR_W-1:0];
  assign dsel = instr[7];

  always_comb begin
    res = 8'h00;
    wr_w = 1'b0;
    wr_f = 1'b0;
    set_z = 1'b0;
    is_branch = 1'b0;
    is_skip = 1'b0;
    known = 1'b1;
    if (instr[13:12] == 2'b10 && instr[11]) begin
      is_branch = 1'b1;
    end else if (instr[13:8] == {2'b11, `CIES_OP_XORL}) begin
      res = working_accumulator ^ instr[7:0];
      wr_w = 1'b1;
      set_z = 1'b1;
    end else if (instr[13:12] == 2'b00) begin
      case (instr[11:8])
        `CIES_OP_DEC: begin
          res = file_rdata - 8'h01;
          is_skip = is_zero(res);
        end
        `CIES_OP_INC: begin
          res = file_rdata + 8'h01;
          set_z = 1'b1;
        end
        `CIES_OP_MOV: begin
          res = file_rdata;
          set_z = 1'b1;
        end
        `CIES_OP_XOR: begin
          res = working_accumulator ^ file_rdata;
          set_z = 1'b1;
        end
        4'h0: begin
          if (dsel) begin
            res = working_accumulator;
            wr_f = 1'b1;
          end else if (instr != `CIES_W_OPTLOAD &&
                       instr[6:0] != 7'h00 && instr[6:0] != 7'h20) begin
            known = 1'b0;
          end
        end
        default: known = 1'b0;
      endcase
      if (instr[11:8] != 4'h0) begin
        wr_w = !dsel;
        wr_f = dsel;
      end
    end else begin
      known = 1'b0;
    end
  end

  wire exec = instr_valid && state_r == CIES_RUN;

  // a flushed slot still consumes a cycle, making skip and branch two cycles
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= CIES_RUN;
    end else if (state_r == CIES_FLUSH) begin
      state_r <= CIES_RUN;
    end else if (exec && (is_branch || is_skip)) begin
      state_r <= CIES_FLUSH;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pc <= '0;
    end else if (reg_wr && reg_addr == `CIES_PCL_ADDR) begin
      pc <= {upper_pc_latch_r, reg_wdata};
    end else if (exec && is_branch) begin
      pc <= {upper_pc_latch_r[4:3], instr[10:0]};
    end else if (instr_valid || state_r == CIES_FLUSH) begin
      pc <= pc + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      instr_taken <= 1'b0;
      file_addr <= '0;
      file_wdata <= 8'h00;
      file_we <= 1'b0;
      illegal_op <= 1'b0;
    end else begin
      instr_taken <= exec;
      file_addr <= fa;
      file_wdata <= res;
      file_we <= exec && wr_f;
      illegal_op <= exec && !known;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      working_accumulator <= 8'h00;
    end else if (reg_wr && reg_addr == `CIES_W_ADDR) begin
      working_accumulator <= reg_wdata;
    end else if (exec && wr_w) begin
      working_accumulator <= res;
    end
  end

  // flags move on set_z or a status register write; dec, branch, store and config leave them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      zero_flag <= 1'b0;
    end else if (exec && set_z) begin
      zero_flag <= is_zero(res);
    end else if (reg_wr && reg_addr == `CIES_STATUS_ADDR) begin
      zero_flag <= reg_wdata[`CIES_Z_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      timer_pin_config <= `CIES_OPT_RESET;
    end else if (exec && instr == `CIES_W_OPTLOAD) begin
      timer_pin_config <= working_accumulator;
    end else if (exec && wr_f && fa == `CIES_OPT_ADDR) begin
      timer_pin_config <= res;
    end else if (reg_wr && reg_addr == `CIES_OPT_ADDR) begin
      timer_pin_config <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      upper_pc_latch_r <= 5'h00;
    end else if (reg_wr && reg_addr == `CIES_UPL_ADDR) begin
      upper_pc_latch_r <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CIES_OPT_ADDR: reg_rdata <= timer_pin_config;
        `CIES_PCL_ADDR: reg_rdata <= pc[7:0];
        `CIES_UPL_ADDR: reg_rdata <= {3'b000, upper_pc_latch_r};
        `CIES_STATUS_ADDR: reg_rdata <= {5'h00, zero_flag, 2'b00};
        `CIES_W_ADDR: reg_rdata <= working_accumulator;
        `CIES_PC_ADDR: reg_rdata <= {3'b000, pc[12:8]};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

/* File: tb/cies_properties.sv */
// assertions on the execution subset ports
`timescale 1ns/1ps
module cies_properties (
  input wire logic clk, rstn, instr_valid, instr_taken, file_we, zero_flag,
  input wire logic [13:0] instr,
  input wire logic [12:0] pc,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_rdata, file_wdata, working_accumulator,
  input wire logic [7:0] timer_pin_config
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic fl_r;
  wire tk = instr_valid && !fl_r;
  wire [5:0] op = instr[13:8];
  // slot after a branch or zero decrement is void
  always_ff @(posedge clk) begin
    if (!rstn)
      fl_r <= 1'b0;
    else
      fl_r <= tk && (instr[13:11] == 3'b101 ||
        op == 6'h0b && file_rdata == 8'h01);
  end
  sequence s_br; tk && instr[13:11] == 3'b101; endsequence
  sequence s_void; fl_r; endsequence
  chk_void_slot: assert property (
    s_void |=> !instr_taken && !file_we) else $error("void slot ran");
  chk_branch_pc: assert property (
    s_br |=> pc[10:0] == $past(instr[10:0]) && $stable(zero_flag))
    else $error("branch target");
  chk_dec_data: assert property (
    tk && op == 6'h0b && instr[7] |=> file_we &&
    file_wdata == $past(file_rdata) - 8'h01 && $stable(zero_flag))
    else $error("decrement");
  chk_inc_acc: assert property (
    tk && op == 6'h0a && !instr[7] |=> working_accumulator ==
    $past(file_rdata) + 8'h01) else $error("increment");
  chk_mov_zero: assert property (
    tk && op == 6'h08 |=> zero_flag == ($past(file_rdata) == 8'h00))
    else $error("move zero");
  chk_store_acc: assert property (
    tk && instr[13:7] == 7'h01 |=> file_we && file_addr ==
    $past(instr[6:0]) && file_wdata == $past(working_accumulator))
    else $error("store");
  chk_cfg_load: assert property (
    tk && instr == 14'h0062 |=> $stable(zero_flag) &&
    timer_pin_config == $past(working_accumulator)) else $error("config");
  chk_xorl_acc: assert property (
    tk && op == 6'h3a |=> working_accumulator ==
    ($past(working_accumulator) ^ $past(instr[7:0]))) else $error("xor");
endmodule
bind cies_core cies_properties u_chk (.clk, .rstn, .instr_valid,
  .instr_taken, .file_we, .zero_flag, .instr, .pc, .file_addr,
  .file_rdata, .file_wdata, .working_accumulator, .timer_pin_config);

/* File: tb/tb_top.sv */
// self-checking bench for the execution subset
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rstn = 0, instr_valid = 0, reg_wr = 0, reg_rd = 0;
  logic [13:0] instr = '0;
  logic [7:0] file_rdata = '0, reg_addr = '0, reg_wdata = '0;
  logic [12:0] pc;
  logic [6:0] file_addr;
  logic [7:0] file_wdata, working_accumulator, timer_pin_config, reg_rdata;
  logic instr_taken, file_we, zero_flag, illegal_op;
  int n_fail = 0, n_tests = 0;
  always #50 clk = ~clk;
  cies_core DUT (.clk, .rstn, .instr, .instr_valid, .pc, .instr_taken,
    .file_addr, .file_rdata, .file_wdata, .file_we, .working_accumulator,
    .zero_flag, .timer_pin_config, .illegal_op, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);
  task ck(input logic [15:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("%0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // second word sits in the slot that the first may void
  task ex(input logic [13:0] i, j, input logic [7:0] d, input bit two);
    @(posedge clk);
    instr <= i;
    file_rdata <= d;
    instr_valid <= 1'b1;
    @(posedge clk);
    if (two) begin
      instr <= j;
      @(posedge clk);
    end
    instr_valid <= 1'b0;
    #1;
  endtask
  // d is write data, or the expected value on a read
  task reg_op(input logic [7:0] a, d, input bit rd);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= !rd;
    reg_rd <= rd;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (rd) ck(reg_rdata, d);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    reg_op(8'h81, 8'hff, 1);
    reg_op(8'h55, 8'h00, 1);
    reg_op(8'h90, 8'hb5, 0);
    ex(14'h3aaf, 0, 0, 0);
    ck(working_accumulator, 8'h1a);
    ex(14'h3a1a, 0, 0, 0);
    ck(zero_flag, 1);
    $display("literal test done");
    reg_op(8'h90, 8'h4f, 0);
    ex(14'h0062, 0, 0, 0);
    ck({zero_flag, timer_pin_config}, 16'h14f);
    reg_op(8'h81, 8'h4f, 1);
    ex(14'h00a5, 0, 0, 0);
    ck({file_we, file_addr, file_wdata}, 16'ha54f);
    ex(14'h0a25, 0, 8'hff, 0);
    ck({zero_flag, working_accumulator}, 16'h100);
    ex(14'h0aa5, 0, 8'h07, 0);
    ck({file_we, file_wdata, zero_flag}, 16'h210);
    ex(14'h0825, 0, 8'h00, 0);
    ck({zero_flag, working_accumulator}, 16'h100);
    ex(14'h0825, 0, 8'h3c, 0);
    ck({zero_flag, working_accumulator}, 16'h03c);
    reg_op(8'h90, 8'hb5, 0);
    ex(14'h06a5, 0, 8'haf, 0);
    ck({file_wdata, working_accumulator}, 16'h1ab5);
    $display("register op test done");
    ex(14'h0ba5, 0, 8'h05, 0);
    ck({file_we, file_wdata}, 16'h104);
    ex(14'h0ba5, 14'h3aff, 8'h01, 1);
    ck({instr_taken, working_accumulator}, 16'h0b5);
    reg_op(8'h0a, 8'h18, 0);
    ex(14'h2cbc, 14'h3aff, 8'h00, 1);
    ck(pc, 16'h1cbd);
    ck({instr_taken, working_accumulator}, 16'h0b5);
    $display("skip and branch test done");
    reg_op(8'h02, 8'h34, 0);
    reg_op(8'h02, 8'h34, 1);
    reg_op(8'h91, 8'h18, 1);
    ex(14'h0b25, 0, 8'h10, 0);
    ck({zero_flag, working_accumulator}, 16'h00f);
    ex(14'h0001, 0, 0, 0);
    ck(illegal_op, 1);
    ex(14'h0000, 0, 0, 0);
    ck({illegal_op, working_accumulator}, 16'h00f);
    $display("pc load and decode test done");
    tally_and_finish;
  end
endmodule
